// ---- dv/prpc_pad_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module prpc_pad_model (
   input wire logic clk,
   input wire logic [39:0] level,
   output logic [prpc_pkg::NUM_PORTS-1:0][prpc_pkg::NUM_PINS-1:0] pad_in
);
   import prpc_pkg::*;

   // Pads move just after an edge, so the block never samples them mid-change
   initial pad_in = '0;
   always @(posedge clk) begin
      pad_in <= #1 level;
   end

endmodule : prpc_pad_model

`default_nettype wire

// ---- dv/tb.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb;
   import prpc_pkg::*;

   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic ce = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] paddr = '0;
   logic [31:0] pwdata = '0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic trace_async_on = 1'b0;
   logic low_speed_crystal_on = 1'b0;
   logic core_off_standby = 1'b0;
   logic vbat_supply = 1'b0;
   logic high_speed_crystal_on = 1'b0;
   logic [39:0] level = '1;
   logic [NUM_PORTS-1:0][NUM_PINS-1:0] pad_in;
   prpc_route_t route;
   prpc_pad_t [NUM_PORTS-1:0][NUM_PINS-1:0] pad_ctrl;
   logic [NUM_PORTS-1:0][NUM_PINS-1:0] input_status;
   int err_count = 0;
   int n_checks = 0;
   int cyc = 0;
   localparam logic [31:0] REMAP_ADDR = REMAP_BASE + REMAP_CFG_OFS;

   always #20 clk = ~clk;

   prpc_pad_model i_pads (.clk(clk), .level(level), .pad_in(pad_in));

   prpc_top i_dut (
      .clk(clk), .nrst(nrst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .trace_async_on(trace_async_on), .low_speed_crystal_on(low_speed_crystal_on),
      .core_off_standby(core_off_standby), .vbat_supply(vbat_supply), .high_speed_crystal_on(high_speed_crystal_on),
      .pad_in(pad_in), .route(route), .pad_ctrl(pad_ctrl), .input_status(input_status)
   );

   ////////////////////////////////////////////////////////////////////////////
   task automatic stop_test;
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : stop_test

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk

   // One bus transfer: setup, access, then release after the edge that samples ready
   task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
      int n;
      n = 0;
      @(posedge clk);
      #1;
      psel = 1'b1;
      pwrite = wr;
      paddr = a;
      pwdata = d;
      @(posedge clk);
      #1;
      penable = 1'b1;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      @(posedge clk);
      #1;
      psel = 1'b0;
      penable = 1'b0;
      chk(32'(n), 32'd1, "ready latency");
   endtask : apb

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
      chk(32'(e), 32'd0, "write error flag");
   endtask : wr

   task automatic rd(input logic [31:0] a, output logic [31:0] r);
      logic e;
      apb(1'b0, a, '0, r, e);
      chk(32'(e), 32'd0, "read error flag");
   endtask : rd

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      logic [31:0] r;
      for (int p = 0; p < NUM_PORTS; p++) begin
         rd(32'(PORT_BASE + p * PORT_STRIDE + CTL0_OFS), r);
         chk(r, CTL0_RESET, "ctl0 reset");
      end
      rd(REMAP_ADDR, r);
      chk(r, 32'h0000_0000, "remap reset");
      chk(route.debug_free, 32'h0000_0000, "debug pins kept");
      chk(route.usart2_loc, U2_PORT_B, "serial2 default");
      chk(route.can0_loc, CAN_PA, "can0 default");
      chk({pad_ctrl[1][3].in_en, pad_ctrl[1][3].out_en}, 32'h0000_0002, "floating");
      $display("test reset done");
   endtask : t_reset

   task automatic t_pins;
      logic [31:0] w;
      logic [31:0] r;
      logic [1:0] md;
      logic [1:0] cf;
      logic out;
      logic an;
      prpc_pad_t pd;
      w = 32'hDB61_C840;
      level = 40'h5A_5A5A_5AA5;
      wr(PORT_BASE, w);
      rd(PORT_BASE, r);
      chk(r, w, "ctl0 readback");
      rd(PORT_BASE + ISTAT_OFS, r);
      chk(r, 32'h0000_00A4, "input status read");
      repeat (3) @(posedge clk);
      #1;
      for (int y = 0; y < NUM_PINS; y++) begin
         md = w[4 * y +: 2];
         cf = w[4 * y + 2 +: 2];
         out = (md != 2'h0);
         an = !out && (cf == 2'h0);
         pd = pad_ctrl[0][y];
         chk(pd.analog, an, "analog");
         chk(pd.in_en, !an, "trigger");
         chk(pd.pull_en, !out && cf == 2'h2, "pull");
         chk(pd.out_en, out, "driver");
         chk(input_status[0][y], level[y] && !an, "input status");
         if (out) begin
            chk({pd.af_drive, pd.open_drain}, cf, "output kind");
            chk(pd.speed, md, "speed");
         end
      end
      $display("test pins done");
   endtask : t_pins

   task automatic t_unmapped;
      logic [31:0] r;
      logic e;
      apb(1'b1, 32'h4001_1C00, 32'hFFFF_FFFF, r, e);
      chk(e, 32'd1, "unmapped write");
      apb(1'b0, 32'h4001_1C00, '0, r, e);
      chk(e, 32'd1, "unmapped read flag");
      chk(r, 32'h0000_0000, "unmapped read data");
      $display("test unmapped done");
   endtask : t_unmapped

   task automatic t_debug;
      logic [2:0] codes [4] = '{3'h0, 3'h1, 3'h4, 3'h2};
      logic [4:0] ex;
      // debug setting with and without trace
      for (int tr = 0; tr < 2; tr++) begin
         for (int k = 0; k < 4; k++) begin
            trace_async_on = tr[0];
            ex = (codes[k] == 3'h4) ? 5'h1F : (codes[k] == 3'h1) ? 5'h10 : 5'h00;
            if (tr == 1) ex[4] = 1'b0;
            wr(REMAP_ADDR, 32'(codes[k]) << SWJ_LSB);
            chk(route.debug_free, ex, "debug pins");
         end
      end
      trace_async_on = 1'b0;
      $display("test debug done");
   endtask : t_debug

   task automatic t_remap;
      prpc_u2_loc_t u2e [4] = '{U2_PORT_B, U2_PORT_C, U2_NONE, U2_PORT_D};
      prpc_can_loc_t cne [4] = '{CAN_PA, CAN_NONE, CAN_PB, CAN_PD};
      logic [31:0] w;
      logic [31:0] r;
      logic [31:0] c;
      logic b;
      for (int i = 0; i < 4; i++) begin
         c = 32'(i);
         b = c[0];
         w = (c << USART2_LSB) | (c << TIM0_LSB) | (c << TIM1_LSB) | (c << TIM2_LSB);
         w = w | (c << CAN0_LSB) | (32'(b) << TIM3_BIT);
         w = w | ({32{b}} & ((32'h1 << SPI0_BIT) | (32'h1 << I2C0_BIT) | (32'h1 << USART1_BIT)));
         w = w | ({32{b}} & ((32'h1 << T4CH3_BIT) | (32'h1 << CAN1_BIT) | (32'h1 << SPI2_BIT)));
         wr(REMAP_ADDR, w);
         chk(route.tim_code, {1'b0, b, c[1:0], c[1:0], c[1:0]}, "timer codes");
         chk(route.tim_routed, {1'b1, c != 1, 1'b1, c != 2}, "timer routed");
         chk(route.usart2_loc, u2e[i], "serial2");
         chk(route.can0_loc, cne[i], "can0");
         chk({route.spi0_remapped, route.i2c0_on_pb8, route.usart1_on_pd}, {3{b}},
             "spi0 i2c serial1");
         chk({route.tim4_ch3_osc, route.can1_remapped, route.spi2_remapped}, {3{b}},
             "osc can1 spi2");
         rd(REMAP_ADDR, r);
         chk(r, w, "remap readback");
      end
      // bits outside the writable mask read back as zero
      wr(REMAP_ADDR, 32'hFFFF_FFFF);
      rd(REMAP_ADDR, r);
      chk(r, REMAP_WMASK, "remap mask");
      chk(route.debug_free, 32'h0000_0000, "forbidden debug code");
      $display("test remap done");
   endtask : t_remap

   task automatic t_xtal;
      prpc_xpin_t pce;
      for (int i = 0; i < 16; i++) begin
         {low_speed_crystal_on, core_off_standby, vbat_supply, high_speed_crystal_on} = 4'(i);
         repeat (2) @(posedge clk);
         #1;
         pce = (core_off_standby || vbat_supply) ? XPIN_ANALOG : low_speed_crystal_on ? XPIN_OSC : XPIN_GPIO;
         chk(route.pc14_15, pce, "low crystal pins");
         chk(route.pd0_1, high_speed_crystal_on ? XPIN_OSC : XPIN_GPIO, "high crystal pins");
      end
      // clock enable low freezes the crystal pin state
      {low_speed_crystal_on, core_off_standby, vbat_supply, high_speed_crystal_on} = 4'h0;
      ce = 1'b0;
      repeat (3) @(posedge clk);
      #1;
      chk(route.pc14_15, XPIN_ANALOG, "frozen crystal pins");
      ce = 1'b1;
      repeat (2) @(posedge clk);
      #1;
      chk(route.pc14_15, XPIN_GPIO, "released crystal pins");
      $display("test crystal done");
   endtask : t_xtal

   ////////////////////////////////////////////////////////////////////////////
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         err_count++;
         $display("ERROR %0t: run too long", $time);
         stop_test();
      end
   end

   initial begin
      repeat (4) @(posedge clk);
      #1;
      nrst = 1'b1;
      t_reset();
      t_pins();
      t_unmapped();
      t_debug();
      t_remap();
      t_xtal();
      stop_test();
   end

endmodule : tb

`default_nettype wire

// ---- logic/prpc_pin_decode.sv ----
`timescale 1ns/1ps
`default_nettype none

module prpc_pin_decode (
   input wire logic [31:0] ctl,
   output prpc_pkg::prpc_pad_t [prpc_pkg::NUM_PINS-1:0] pads
);
   import prpc_pkg::*;

   for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
      logic [1:0] mode;
      logic [1:0] cfg;
      logic is_in;
      assign mode = ctl[i*FIELD_W+MODE_LSB +: 2];
      assign cfg = ctl[i*FIELD_W+CFG_LSB +: 2];
      assign is_in = (mode == MODE_IN);
      assign pads[i].speed = mode;
      assign pads[i].analog = is_in && (cfg == CFG_ANALOG);
      assign pads[i].pull_en = is_in && (cfg == CFG_PULL);
      assign pads[i].in_en = !(is_in && (cfg == CFG_ANALOG));
      assign pads[i].out_en = !is_in;
      assign pads[i].af_drive = !is_in && cfg[CFG_AF_BIT];
      assign pads[i].open_drain = !is_in && cfg[CFG_OD_BIT];
   end

endmodule : prpc_pin_decode
`default_nettype wire

// ---- logic/prpc_pkg.sv ----
package prpc_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Address map
   localparam logic [31:0] REMAP_BASE = 32'h4001_0000;
   localparam logic [31:0] REMAP_CFG_OFS = 32'h0000_0004;
   localparam logic [31:0] PORT_BASE = 32'h4001_0800;
   localparam logic [31:0] PORT_STRIDE = 32'h0000_0400;
   localparam logic [31:0] CTL0_OFS = 32'h0000_0000;
   localparam logic [31:0] ISTAT_OFS = 32'h0000_0008;
   localparam int NUM_PORTS = 5;
   localparam int NUM_PINS = 8;
   localparam int PORT_C = 2;

   ////////////////////////////////////////////////////////////////////////////
   // Reset values and masks
   localparam logic [31:0] CTL0_RESET = 32'h4444_4444;
   localparam logic [31:0] REMAP_RESET = 32'h0000_0000;
   localparam logic [31:0] REMAP_WMASK = 32'h1741_7FFB;
   localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

   ////////////////////////////////////////////////////////////////////////////
   // Remap register field positions
   localparam int SPI0_BIT = 0;
   localparam int I2C0_BIT = 1;
   localparam int USART1_BIT = 3;
   localparam int USART2_LSB = 4;
   localparam int TIM0_LSB = 6;
   localparam int TIM1_LSB = 8;
   localparam int TIM2_LSB = 10;
   localparam int TIM3_BIT = 12;
   localparam int CAN0_LSB = 13;
   localparam int T4CH3_BIT = 16;
   localparam int CAN1_BIT = 22;
   localparam int SWJ_LSB = 24;
   localparam int SPI2_BIT = 28;

   ////////////////////////////////////////////////////////////////////////////
   // Codes
   localparam logic [2:0] DBG_ALL_ON = 3'h0;
   localparam logic [2:0] DBG_NO_RST = 3'h1;
   localparam logic [2:0] DBG_ALL_OFF = 3'h4;
   localparam logic [4:0] DBG_NONE_FREE = 5'h00;
   localparam logic [4:0] DBG_RST_FREE = 5'h10;
   localparam logic [4:0] DBG_ALL_FREE = 5'h1F;
   localparam int DBG_RST_IDX = 4;
   // Legal codes of each timer selector, one bit per code
   localparam logic [3:0][3:0] TIM_CODE_OK = {4'h3, 4'hD, 4'hF, 4'hB};
   localparam logic [1:0] TIM0_UNUSED = 2'h2;
   localparam logic [1:0] U2_NONE_CODE = 2'h2;

   ////////////////////////////////////////////////////////////////////////////
   // Pin field layout and codes
   localparam int FIELD_W = 4;
   localparam int MODE_LSB = 0;
   localparam int CFG_LSB = 2;
   localparam logic [1:0] MODE_IN = 2'h0;
   localparam logic [1:0] CFG_ANALOG = 2'h0;
   localparam logic [1:0] CFG_PULL = 2'h2;
   localparam int CFG_OD_BIT = 0;
   localparam int CFG_AF_BIT = 1;

   typedef enum logic [1:0] {U2_PORT_B, U2_PORT_C, U2_PORT_D, U2_NONE} prpc_u2_loc_t;
   typedef enum logic [1:0] {CAN_PA, CAN_PB, CAN_PD, CAN_NONE} prpc_can_loc_t;
   typedef enum logic [1:0] {XPIN_GPIO, XPIN_OSC, XPIN_ANALOG} prpc_xpin_t;

   typedef struct packed {
      logic analog;
      logic in_en;
      logic pull_en;
      logic out_en;
      logic af_drive;
      logic open_drain;
      logic [1:0] speed;
   } prpc_pad_t;

   typedef struct packed {
      logic [4:0] debug_free;
      logic [3:0][1:0] tim_code;
      logic [3:0] tim_routed;
      logic tim4_ch3_osc;
      logic usart1_on_pd;
      prpc_u2_loc_t usart2_loc;
      logic i2c0_on_pb8;
      logic spi0_remapped;
      logic spi2_remapped;
      prpc_can_loc_t can0_loc;
      logic can1_remapped;
      prpc_xpin_t pc14_15;
      prpc_xpin_t pd0_1;
   } prpc_route_t;

endpackage : prpc_pkg

// ---- logic/prpc_top.sv ----
// Overview of operation
// - Debug setting 000 keeps all, 001 frees reset pin, 100 frees all.
// - Reset leaves the debug port fully enabled, setting 000.
// - Debug reset pin stays reserved while asynchronous trace runs.
// - Each timer 0..3 selector picks pin set; unused codes unrouted.
// - Timer 4 channel 3 takes port A3 or internal 40 kHz oscillator.
// - Serial 1 remap moves its five signals from A0..A4 to D3..D7.
// - Serial 2 code 01 moves data/clock to C10..C12, flow stays B13/B14.
// - Serial 2 code 11 puts all five signals on D8..D12.
// - First I2C sits on B6/B7, or B8/B9 when remapped.
// - SPI0 moves to A15,B3..B5; SPI2 moves to A4,C10..C12.
// - CAN0 code picks A11/12, B8/9 or D0/1; CAN1 bit picks pins.
// - Low-speed crystal pins are GPIO only while that oscillator is off.
// - Standby or battery supply forces those pins into analog mode.
// - High-speed crystal pins are GPIO D0/D1 only while oscillator off.
// - Remap block at 0x4001_0000, ports every 0x400 from 0x4001_0800.
// - Pin y config at bits 4y+3:4y+2, mode at bits 4y+1:4y.
// - Mode 00 input, 01 10 MHz, 10 2 MHz, 11 50 MHz output.
// - Input config: analog, floating, pull up/down, reserved.
// - Output config: GPIO push-pull/open-drain, AF push-pull/open-drain.
// - Control register 0 at offset 0x00, read/write, resets 0x4444_4444.
// - Analog pin disables pulls, driver, trigger; its input status is 0.
// - Registers reached through a peripheral-bus slave interface.
`timescale 1ns/1ps
`default_nettype none

module prpc_top (
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic trace_async_on,
   input wire logic low_speed_crystal_on,
   input wire logic core_off_standby,
   input wire logic vbat_supply,
   input wire logic high_speed_crystal_on,
   input wire logic [prpc_pkg::NUM_PORTS-1:0][prpc_pkg::NUM_PINS-1:0] pad_in,
   output prpc_pkg::prpc_route_t route,
   output prpc_pkg::prpc_pad_t [prpc_pkg::NUM_PORTS-1:0][prpc_pkg::NUM_PINS-1:0] pad_ctrl,
   output logic [prpc_pkg::NUM_PORTS-1:0][prpc_pkg::NUM_PINS-1:0] input_status
);
   import prpc_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Address decode

   function automatic logic addr_hit(input logic [31:0] a, input logic [31:0] base,
                                     input logic [31:0] ofs);
      return a == (base + ofs);
   endfunction : addr_hit

   function automatic logic [31:0] port_base(input int p);
      return PORT_BASE + 32'(p) * PORT_STRIDE;
   endfunction : port_base

   logic [31:0] remap_reg;
   logic [31:0] remap_next;
   logic [NUM_PORTS-1:0][31:0] ctl_reg;
   logic [NUM_PORTS-1:0][31:0] ctl_next;
   logic pready_reg;
   logic pslverr_reg;
   logic [31:0] prdata_reg;
   logic [31:0] rdata_next;
   logic err_next;
   logic access;
   prpc_route_t route_reg;
   prpc_route_t route_next;
   prpc_pad_t [NUM_PORTS-1:0][NUM_PINS-1:0] pad_reg;
   prpc_pad_t [NUM_PORTS-1:0][NUM_PINS-1:0] pad_dec;
   logic [NUM_PORTS-1:0][NUM_PINS-1:0] istat_reg;
   logic [NUM_PORTS-1:0][NUM_PINS-1:0] analog_mask;

   assign access = ce && psel && penable && !pready_reg;

   always_comb begin
      rdata_next = ZERO_WORD;
      err_next = 1'b1;
      remap_next = remap_reg;
      if (addr_hit(paddr, REMAP_BASE, REMAP_CFG_OFS)) begin
         err_next = 1'b0;
         rdata_next = remap_reg;
         if (access && pwrite) begin
            remap_next = pwdata & REMAP_WMASK;
         end
      end
      for (int p = 0; p < NUM_PORTS; p++) begin
         ctl_next[p] = ctl_reg[p];
         if (addr_hit(paddr, port_base(p), CTL0_OFS)) begin
            err_next = 1'b0;
            rdata_next = ctl_reg[p];
            if (access && pwrite) begin
               ctl_next[p] = pwdata;
            end
         end
         if (addr_hit(paddr, port_base(p), ISTAT_OFS)) begin
            err_next = 1'b0;
            rdata_next = {24'h00_0000, istat_reg[p]};
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= ZERO_WORD;
      end else if (ce) begin
         pready_reg <= access;
         pslverr_reg <= access && err_next;
         prdata_reg <= (access && !pwrite) ? rdata_next : ZERO_WORD;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Configuration registers

   always_ff @(posedge clk) begin
      if (!nrst) begin
         remap_reg <= REMAP_RESET;
      end else if (ce) begin
         remap_reg <= remap_next;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         ctl_reg <= {NUM_PORTS{CTL0_RESET}};
      end else if (ce) begin
         ctl_reg <= ctl_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Route decode

   always_comb begin
      logic [1:0] code;
      code = 2'h0;
      route_next = '0;
      case (remap_next[SWJ_LSB +: 3])
         DBG_NO_RST: route_next.debug_free = DBG_RST_FREE;
         DBG_ALL_OFF: route_next.debug_free = DBG_ALL_FREE;
         default: route_next.debug_free = DBG_NONE_FREE;
      endcase
      if (trace_async_on) begin
         route_next.debug_free[DBG_RST_IDX] = 1'b0;
      end
      route_next.tim_code[0] = remap_next[TIM0_LSB +: 2];
      route_next.tim_code[1] = remap_next[TIM1_LSB +: 2];
      route_next.tim_code[2] = remap_next[TIM2_LSB +: 2];
      route_next.tim_code[3] = {1'b0, remap_next[TIM3_BIT]};
      for (int t = 0; t < 4; t++) begin
         code = route_next.tim_code[t];
         route_next.tim_routed[t] = TIM_CODE_OK[t][code];
      end
      route_next.tim4_ch3_osc = remap_next[T4CH3_BIT];
      route_next.usart1_on_pd = remap_next[USART1_BIT];
      case (remap_next[USART2_LSB +: 2])
         2'h0: route_next.usart2_loc = U2_PORT_B;
         2'h1: route_next.usart2_loc = U2_PORT_C;
         2'h3: route_next.usart2_loc = U2_PORT_D;
         default: route_next.usart2_loc = U2_NONE;
      endcase
      route_next.i2c0_on_pb8 = remap_next[I2C0_BIT];
      route_next.spi0_remapped = remap_next[SPI0_BIT];
      route_next.spi2_remapped = remap_next[SPI2_BIT];
      case (remap_next[CAN0_LSB +: 2])
         2'h0: route_next.can0_loc = CAN_PA;
         2'h2: route_next.can0_loc = CAN_PB;
         2'h3: route_next.can0_loc = CAN_PD;
         default: route_next.can0_loc = CAN_NONE;
      endcase
      route_next.can1_remapped = remap_next[CAN1_BIT];
      if (core_off_standby || vbat_supply) begin
         route_next.pc14_15 = XPIN_ANALOG;
      end else if (low_speed_crystal_on) begin
         route_next.pc14_15 = XPIN_OSC;
      end else begin
         route_next.pc14_15 = XPIN_GPIO;
      end
      route_next.pd0_1 = high_speed_crystal_on ? XPIN_OSC : XPIN_GPIO;
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         route_reg <= '0;
      end else if (ce) begin
         route_reg <= route_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pad decode and input status

   for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
      prpc_pin_decode u_dec (
         .ctl(ctl_next[p]),
         .pads(pad_dec[p])
      );
      for (genvar i = 0; i < NUM_PINS; i++) begin : g_mask
         assign analog_mask[p][i] = pad_reg[p][i].analog;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         pad_reg <= '0;
      end else if (ce) begin
         pad_reg <= pad_dec;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         istat_reg <= '0;
      end else if (ce) begin
         for (int p = 0; p < NUM_PORTS; p++) begin
            for (int i = 0; i < NUM_PINS; i++) begin
               istat_reg[p][i] <= pad_in[p][i] && !pad_dec[p][i].analog;
            end
         end
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign route = route_reg;
   assign pad_ctrl = pad_reg;
   assign input_status = istat_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   dbg_reset_state_a: assert property ($rose(nrst) |->
      remap_reg[SWJ_LSB +: 3] == DBG_ALL_ON && route_reg.debug_free == DBG_NONE_FREE)
      else $error("debug port not fully on after reset");

   dbg_all_free_a: assert property (
      remap_reg[SWJ_LSB +: 3] == DBG_ALL_OFF |->
      (route_reg.debug_free | DBG_RST_FREE) == DBG_ALL_FREE &&
      (route_reg.debug_free[DBG_RST_IDX] || $past(trace_async_on) || !$past(ce)))
      else $error("code 100 does not free all debug pins");

   trace_hold_a: assert property (
      $past(ce) && $past(trace_async_on) |-> !route_reg.debug_free[DBG_RST_IDX])
      else $error("debug reset pin freed during trace");

   tim_unused_a: assert property (
      route_reg.tim_code[0] == TIM0_UNUSED |-> !route_reg.tim_routed[0])
      else $error("unused timer code routed");

   u2_none_a: assert property (
      remap_reg[USART2_LSB +: 2] == U2_NONE_CODE |-> route_reg.usart2_loc == U2_NONE)
      else $error("serial 2 routed on unused code");

   xpin_analog_a: assert property (
      $past(nrst) && $past(ce) && $past(core_off_standby || vbat_supply) |->
      route_reg.pc14_15 == XPIN_ANALOG)
      else $error("crystal pins not analog on power loss");

   ctl0_reset_a: assert property ($rose(nrst) |->
      ctl_reg == {NUM_PORTS{CTL0_RESET}} ##1 !pad_reg[0][0].analog)
      else $error("control register reset value wrong");

   ctl0_write_a: assert property (
      access && pwrite && addr_hit(paddr, PORT_BASE, CTL0_OFS) |=>
      ctl_reg[0] == $past(pwdata) && pad_reg[0][0].speed == $past(pwdata[1:0]))
      else $error("control write or pad decode late");

   analog_status_a: assert property (
      (istat_reg & analog_mask) == '0)
      else $error("analog pin reports input high");

   bus_ready_a: assert property (
      access |=> pready_reg ##1 !pready_reg)
      else $error("ready not one cycle after access");

   bus_error_a: assert property (
      access && addr_hit(paddr, REMAP_BASE, REMAP_CFG_OFS) |=> !pslverr_reg)
      else $error("remap register flagged as unmapped");

endmodule : prpc_top
`default_nettype wire
